// *** sfc_assertions.sv ***
`timescale 1ns/1ps
// Watches the link between controller and device; standard timing is assumed.
module sfc_assertions
    import sfc_pkg::*;
#(
    parameter bit CHAIN_MODE = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic offset_load_n,
    input wire logic fifo_reset_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic write_chain_out,
    input wire logic read_chain_out,
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    input wire logic almost_empty_n,
    input wire logic almost_full_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Data strobes only; offset accesses leave the pointers alone and flushes clear them.
    logic data_wr;
    logic data_rd;
    assign data_wr = !write_en_n && offset_load_n && fifo_reset_n;
    assign data_rd = !read_en_n && offset_load_n && fifo_reset_n;
    // Flag relations, flag timing after data writes, data reads and flushes, offset read width and idle chain outputs.
    AST_FULL_ALMOST: assert property (!full_flag_n |-> !almost_full_n)
        else $error("full without almost full");
    AST_EMPTY_ALMOST: assert property (!empty_flag_n |-> !almost_empty_n)
        else $error("empty without almost empty");
    AST_FULL_NOT_EMPTY: assert property (full_flag_n || empty_flag_n)
        else $error("full and empty together");
    AST_WRITE_FILLS: assert property (data_wr && !empty_flag_n |-> ##[1:3] empty_flag_n)
        else $error("empty flag stuck after write");
    AST_READ_FREES: assert property (data_rd && !full_flag_n |=> full_flag_n)
        else $error("full flag stuck after read");
    AST_FULL_HOLDS: assert property (data_wr && read_en_n && !full_flag_n |=> !full_flag_n)
        else $error("write taken while full");
    AST_EMPTY_HOLDS: assert property (data_rd && write_en_n && !empty_flag_n |=> !empty_flag_n)
        else $error("read taken while empty");
    AST_FLUSH: assert property (!fifo_reset_n |=> full_flag_n && almost_full_n
        && !empty_flag_n && !almost_empty_n)
        else $error("flags wrong after flush");
    AST_OFS_UPPER: assert property (!offset_load_n && !read_en_n
        |=> data_out[DATA_W-1:OFS_W] == '0)
        else $error("offset read upper bits set");
    AST_CHAIN_IDLE: assert property (!CHAIN_MODE |-> write_chain_out && read_chain_out)
        else $error("chain pulse outside chain");
    // Main scenarios reached.
    cover property (!full_flag_n);
    cover property (!offset_load_n && !read_en_n);
    cover property (!empty_flag_n ##1 empty_flag_n);
endmodule // sfc_assertions

// *** sfc_buf.sv ***
`timescale 1ns/1ps
module sfc_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sfc_buf depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
    logic do_w, do_r;
    // Pointers carry a wrap bit so full and empty are exact.
    always_comb begin
        in_ready = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
        out_valid = wp_reg != rp_reg;
        do_w = in_valid && in_ready;
        do_r = out_valid && out_ready;
        wp_next = do_w ? wp_reg + 1'b1 : wp_reg;
        rp_next = do_r ? rp_reg + 1'b1 : rp_reg;
        out_data = mem[rp_reg[AW-1:0]];
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end
    // Storage has no reset so it can map onto RAM.
    always_ff @(posedge clk_sys) begin
        if (do_w) mem[wp_reg[AW-1:0]] <= in_data;
    end
endmodule // sfc_buf

// *** sfc_ctl.sv ***
`timescale 1ns/1ps
module sfc_ctl
    import sfc_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter bit FIRST_DEVICE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    sfc_if.ctl bus,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic ofs_wr,
    input wire logic ofs_rd,
    input wire logic [OFS_W-1:0] ofs_data,
    input wire logic rd_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    input wire logic prev_write_chain,
    input wire logic prev_read_chain
);
    logic b_valid, b_ready, b_in_ready;
    logic [DATA_W-1:0] b_data;
    logic wen_reg, wen_next, ren_reg, ren_next, ld_reg, ld_next;
    logic [DATA_W-1:0] d_reg, d_next;
    logic rv_reg, rv_next;
    logic rs_reg, rs_next, flush_n_reg, flush_n_next;
    logic [DATA_W-1:0] rd_reg, rd_next;
    sfc_buf #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_buf (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(wr_valid),
        .in_ready(b_in_ready),
        .in_data(wr_data),
        .out_valid(b_valid),
        .out_ready(b_ready),
        .out_data(b_data)
    );
    // Drain the buffer one word every other cycle while the device is not full; an
    // offset access takes priority so its pins never overlap a data write.
    always_comb begin
        b_ready = bus.full_flag_n && !ofs_wr && !ofs_rd && wen_reg;
        wen_next = !(b_valid && b_ready) && !ofs_wr;
        ld_next = !(ofs_wr || ofs_rd);
        ren_next = !(ofs_rd || (rd_ready && bus.empty_flag_n && ren_reg));
        d_next = ofs_wr ? {{(DATA_W-OFS_W){1'b0}}, ofs_data} : b_data;
        // The device loads its output on the edge that takes the read, so the
        // word is only settled one cycle after that edge.
        rs_next = !ren_reg && ld_reg;
        rv_next = rs_reg;
        rd_next = bus.data_out;
        // The device flush is held one cycle past reset so it starts cleanly.
        flush_n_next = 1'b1;
    end
    // Strobes, read capture and flush release are registered together.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wen_reg <= 1'b1;
            ren_reg <= 1'b1;
            ld_reg <= 1'b1;
            d_reg <= '0;
            rs_reg <= 1'b0;
            rv_reg <= 1'b0;
            rd_reg <= '0;
            flush_n_reg <= 1'b0;
        end else begin
            wen_reg <= wen_next;
            ren_reg <= ren_next;
            ld_reg <= ld_next;
            d_reg <= d_next;
            rs_reg <= rs_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            flush_n_reg <= flush_n_next;
        end
    end
    assign wr_ready = b_in_ready;
    assign rd_valid = rv_reg;
    assign rd_data = rd_reg;
    assign bus.write_en_n = wen_reg;
    assign bus.read_en_n = ren_reg;
    assign bus.offset_load_n = ld_reg;
    assign bus.data_in = d_reg;
    assign bus.fifo_reset_n = flush_n_reg;
    assign bus.first_device_sel = !FIRST_DEVICE;
    assign bus.write_chain_in = prev_write_chain;
    assign bus.read_chain_in = prev_read_chain;
endmodule // sfc_ctl

// *** sfc_dev.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Load low plus write captures offset.
// - Load low plus read shows offset.
// - Mode pins pick timing and flag style outside chain mode.
// - Chain first device ties select low.
// - Chain-out of previous feeds chain-in.
// - Standard mode: full flag on full.
// - Fall-through: input-ready shows free space.
// - Standard mode: empty flag on empty.
// - Fall-through: output-ready shows valid output.
// - Almost-empty at or below empty offset.
// - Almost-full at or below full offset.
// - Half-full low above half occupancy.
// - Pulse write chain on last location.
// - Pulse read chain on last location.
// - Output bus eighteen bits wide.
// - Reset clears pointers, sets flag levels.
// - Ignore writes when full, reads empty.
// - First word falls through after three.
module sfc_dev
    import sfc_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF,
    parameter bit CHAIN_MODE = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    sfc_if.dev bus,
    output logic half_full_n,
    output logic fall_through_mode,
    output logic flags_async
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [OFS_W-1:0] OFS_RST = (DEPTH <= DEPTH_SMALL) ? OFS_RST_SMALL :
        (DEPTH <= DEPTH_MID) ? OFS_RST_MID : OFS_RST_LARGE;
    initial begin
        if ((1 << AW) != DEPTH || AW > OFS_W) $error("sfc_dev depth unsupported");
    end
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW:0] wp_reg, wp_next, rp_reg, rp_next, cnt;
    logic [OFS_W-1:0] eofs_reg, eofs_next, fofs_reg, fofs_next;
    sfc_ofs_sel_t wsel_reg, wsel_next, rsel_reg, rsel_next;
    logic [DATA_W-1:0] q_reg, q_next;
    logic ov_reg, ov_next;
    logic [1:0] ft_cnt_reg, ft_cnt_next;
    logic mode_ft_reg, mode_ft_next, mode_as_reg, mode_as_next;
    logic cap_reg, cap_next;
    logic ff_reg, ff_next, ef_reg, ef_next, ae_reg, ae_next, af_reg, af_next;
    logic hf_reg, hf_next, wxo_reg, wxo_next, rxo_reg, rxo_next;
    logic full, empty, do_w, do_r, ld_w, ld_r;
    logic [AW:0] cnt_n, free_n;
    // Main next-state logic.
    always_comb begin
        cnt = wp_reg - rp_reg;
        full = cnt == (AW+1)'(DEPTH);
        empty = cnt == '0;
        ld_w = !bus.offset_load_n && !bus.write_en_n;
        ld_r = !bus.offset_load_n && !bus.read_en_n;
        do_w = !ld_w && !bus.write_en_n && !full;
        // The first word waits out the fall-through count before it is shown.
        if (mode_ft_reg)
            do_r = !empty && ((!ov_reg && ft_cnt_reg == 2'(FALL_THROUGH_MODE_LAT - 1))
                || (ov_reg && !bus.read_en_n && bus.offset_load_n));
        else
            do_r = !ld_r && !bus.read_en_n && !empty;
        wp_next = do_w ? wp_reg + 1'b1 : wp_reg;
        rp_next = do_r ? rp_reg + 1'b1 : rp_reg;
        cnt_n = wp_next - rp_next;
        free_n = (AW+1)'(DEPTH) - cnt_n;
        eofs_next = eofs_reg;
        fofs_next = fofs_reg;
        wsel_next = wsel_reg;
        if (ld_w) begin
            if (wsel_reg == SFC_OFS_EMPTY) begin
                eofs_next = bus.data_in[OFS_W-1:0];
                wsel_next = SFC_OFS_FULL;
            end else begin
                fofs_next = bus.data_in[OFS_W-1:0];
                wsel_next = SFC_OFS_EMPTY;
            end
        end
        q_next = q_reg;
        rsel_next = rsel_reg;
        if (ld_r) begin
            q_next = {{(DATA_W-OFS_W){1'b0}},
                      (rsel_reg == SFC_OFS_EMPTY) ? eofs_reg : fofs_reg};
            rsel_next = (rsel_reg == SFC_OFS_EMPTY) ? SFC_OFS_FULL : SFC_OFS_EMPTY;
        end else if (do_r) begin
            q_next = mem[rp_reg[AW-1:0]];
        end
        ft_cnt_next = ft_cnt_reg;
        ov_next = ov_reg;
        if (mode_ft_reg) begin
            if (do_r) ov_next = 1'b1;
            else if (!bus.read_en_n && bus.offset_load_n) ov_next = 1'b0;
            if (!empty && !ov_reg && ft_cnt_reg != 2'(FALL_THROUGH_MODE_LAT - 1))
                ft_cnt_next = ft_cnt_reg + 2'h1;
            else
                ft_cnt_next = 2'h0;
        end
        mode_ft_next = mode_ft_reg;
        mode_as_next = mode_as_reg;
        cap_next = 1'b0;
        if (cap_reg && !CHAIN_MODE) begin
            mode_ft_next = !bus.first_device_sel;
            mode_as_next = bus.write_chain_in ^ bus.read_chain_in;
        end
        ff_next = !(cnt_n == (AW+1)'(DEPTH));
        ef_next = !(cnt_n == '0);
        if (mode_ft_reg) ef_next = !(ov_next);
        ae_next = !((AW+1+OFS_W)'(cnt_n) <= (AW+1+OFS_W)'(eofs_next));
        af_next = !((AW+1+OFS_W)'(free_n) <= (AW+1+OFS_W)'(fofs_next));
        hf_next = !(cnt_n > (AW+1)'(DEPTH / 2));
        wxo_next = !(CHAIN_MODE && do_w && wp_reg[AW-1:0] == '1);
        rxo_next = !(CHAIN_MODE && do_r && rp_reg[AW-1:0] == '1);
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
            eofs_reg <= OFS_RST;
            fofs_reg <= OFS_RST;
            wsel_reg <= SFC_OFS_EMPTY;
            rsel_reg <= SFC_OFS_EMPTY;
            q_reg <= '0;
            ov_reg <= 1'b0;
            ft_cnt_reg <= 2'h0;
            mode_ft_reg <= 1'b0;
            mode_as_reg <= 1'b0;
            cap_reg <= 1'b1;
            ff_reg <= 1'b1;
            ef_reg <= 1'b0;
            ae_reg <= 1'b0;
            af_reg <= 1'b1;
            hf_reg <= 1'b1;
            wxo_reg <= 1'b1;
            rxo_reg <= 1'b1;
        end else if (!bus.fifo_reset_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            ov_reg <= 1'b0;
            ft_cnt_reg <= 2'h0;
            ff_reg <= 1'b1;
            ef_reg <= 1'b0;
            ae_reg <= 1'b0;
            af_reg <= 1'b1;
            hf_reg <= 1'b1;
            cap_reg <= 1'b1;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            eofs_reg <= eofs_next;
            fofs_reg <= fofs_next;
            wsel_reg <= wsel_next;
            rsel_reg <= rsel_next;
            q_reg <= q_next;
            ov_reg <= ov_next;
            ft_cnt_reg <= ft_cnt_next;
            mode_ft_reg <= mode_ft_next;
            mode_as_reg <= mode_as_next;
            cap_reg <= cap_next;
            ff_reg <= ff_next;
            ef_reg <= ef_next;
            ae_reg <= ae_next;
            af_reg <= af_next;
            hf_reg <= hf_next;
            wxo_reg <= wxo_next;
            rxo_reg <= rxo_next;
        end
    end
    // Storage array kept without reset to map onto RAM.
    always_ff @(posedge clk_sys) begin
        if (do_w) mem[wp_reg[AW-1:0]] <= bus.data_in;
    end
    assign bus.data_out = q_reg;
    // input ready shares the full pin
    assign bus.full_flag_n = ff_reg;
    assign bus.empty_flag_n = ef_reg;
    assign bus.almost_empty_n = ae_reg;
    assign bus.almost_full_n = af_reg;
    assign bus.write_chain_out = wxo_reg;
    assign bus.read_chain_out = rxo_reg;
    assign half_full_n = hf_reg;
    assign fall_through_mode = mode_ft_reg;
    assign flags_async = mode_as_reg;
endmodule // sfc_dev

// *** sfc_if.sv ***
`timescale 1ns/1ps
interface sfc_if;
    import sfc_pkg::*;
    logic write_en_n;
    logic read_en_n;
    logic offset_load_n;
    logic fifo_reset_n;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic first_device_sel;
    logic write_chain_in;
    logic read_chain_in;
    logic write_chain_out;
    logic read_chain_out;
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_empty_n;
    logic almost_full_n;
    modport dev (
        input write_en_n, read_en_n, offset_load_n, fifo_reset_n, data_in,
        input first_device_sel, write_chain_in, read_chain_in,
        output data_out, write_chain_out, read_chain_out,
        output full_flag_n, empty_flag_n, almost_empty_n, almost_full_n
    );
    modport ctl (
        output write_en_n, read_en_n, offset_load_n, fifo_reset_n, data_in,
        output first_device_sel, write_chain_in, read_chain_in,
        input data_out, write_chain_out, read_chain_out,
        input full_flag_n, empty_flag_n, almost_empty_n, almost_full_n
    );
endinterface

// *** sfc_pkg.sv ***
package sfc_pkg;
    localparam int DATA_W = 18;
    localparam int OFS_W = 12;
    localparam int DEPTH_DEF = 256;
    // Default offsets per depth: 256 -> 31, 512 -> 63, larger -> 127.
    localparam logic [11:0] OFS_RST_SMALL = 12'h01f;
    localparam logic [11:0] OFS_RST_MID = 12'h03f;
    localparam logic [11:0] OFS_RST_LARGE = 12'h07f;
    localparam int DEPTH_SMALL = 256;
    localparam int DEPTH_MID = 512;
    // Fall-through latency in read-clock transitions.
    localparam int FALL_THROUGH_MODE_LAT = 3;
    localparam int BUF_DEPTH = 32;
    // Offset-access state machine.
    typedef enum logic [0:0] {
        SFC_OFS_EMPTY = 1'b0,
        SFC_OFS_FULL = 1'b1
    } sfc_ofs_sel_t;
endpackage

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import sfc_pkg::*;
    logic clk_sys, rst_b, wr_valid, wr_ready, ofs_wr, ofs_rd, rd_ready, rd_valid;
    logic half_full_n, fall_through_mode, flags_async;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [OFS_W-1:0] ofs_data;
    int err_count, check_count, acc, lvl, t;
    bit ok;
    sfc_if bus_if ();
    sfc_dev #(.DEPTH(DEPTH_SMALL), .CHAIN_MODE(1'b0)) u_sfc_dev (.clk_sys(clk_sys),
        .rst_b(rst_b), .bus(bus_if.dev), .half_full_n(half_full_n),
        .fall_through_mode(fall_through_mode), .flags_async(flags_async));
    // Not first in a chain, so the mode pins should pick standard timing.
    sfc_ctl #(.DEPTH(BUF_DEPTH), .FIRST_DEVICE(1'b0)) u_sfc_ctl (.clk_sys(clk_sys),
        .rst_b(rst_b), .bus(bus_if.ctl), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .ofs_wr(ofs_wr), .ofs_rd(ofs_rd), .ofs_data(ofs_data),
        .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .prev_write_chain(1'b1), .prev_read_chain(1'b1));
    sfc_assertions #(.CHAIN_MODE(1'b0)) u_sfc_assertions (.clk_sys(clk_sys), .rst_b(rst_b),
        .write_en_n(bus_if.write_en_n), .read_en_n(bus_if.read_en_n),
        .offset_load_n(bus_if.offset_load_n), .fifo_reset_n(bus_if.fifo_reset_n),
        .data_out(bus_if.data_out), .write_chain_out(bus_if.write_chain_out),
        .read_chain_out(bus_if.read_chain_out), .full_flag_n(bus_if.full_flag_n),
        .empty_flag_n(bus_if.empty_flag_n), .almost_empty_n(bus_if.almost_empty_n),
        .almost_full_n(bus_if.almost_full_n));
    // Free-running 10 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        idle(10);
        rst_b = 1'b1;
        idle(2);
    endtask
    // Flags packed as full, almost full, half full, almost empty, empty.
    function automatic logic [DATA_W-1:0] flags();
        return DATA_W'({bus_if.full_flag_n, bus_if.almost_full_n, half_full_n,
            bus_if.almost_empty_n, bus_if.empty_flag_n});
    endfunction
    // One offset access held for a single cycle, then time for the answer.
    task automatic ofs_access(input bit rd, input logic [OFS_W-1:0] d);
        ofs_wr = !rd;
        ofs_rd = rd;
        ofs_data = d;
        @(negedge clk_sys);
        ofs_wr = 1'b0;
        ofs_rd = 1'b0;
        idle(4);
    endtask
    // Offers one word; ok stays low if the buffer never takes it.
    task automatic push(input logic [DATA_W-1:0] d, output bit ok);
        ok = 1'b0;
        wr_valid = 1'b1;
        wr_data = d;
        // Ready is looked at before the edge that takes the word, never on it.
        for (int i = 0; i < 20 && !ok; i++) begin
            ok = (wr_ready === 1'b1);
            @(negedge clk_sys);
        end
        wr_valid = 1'b0;
    endtask
    initial begin
        {wr_valid, ofs_wr, ofs_rd, rd_ready} = '0;
        wr_data = '0;
        ofs_data = '0;
        do_reset();
        check(flags(), 18'h0001c);
        // Select high and both chain inputs high pick standard timing, synchronous flags.
        check(DATA_W'(fall_through_mode), 18'h00000);
        check(DATA_W'(flags_async), 18'h00000);
        // Defaults first, then programmed values, read back in access order.
        ofs_access(1'b1, '0);
        check(bus_if.data_out, 18'h0001f);
        ofs_access(1'b1, '0);
        check(bus_if.data_out, 18'h0001f);
        ofs_access(1'b0, 12'h005);
        ofs_access(1'b0, 12'h007);
        ofs_access(1'b1, '0);
        check(bus_if.data_out, 18'h00005);
        ofs_access(1'b1, '0);
        check(bus_if.data_out, 18'h00007);
        // A second reset restores the default offsets before the fill.
        do_reset();
        for (acc = 0; acc < 300; acc++) begin
            push({2'b10, acc[15:0]}, ok);
            if (!ok) break;
            idle(8);
            lvl = (acc < 256) ? acc + 1 : 256;
            check(flags(), DATA_W'({lvl < 256, lvl < 225, lvl <= 128, lvl > 31, 1'b1}));
        end
        check(DATA_W'(acc >= 288 && acc < 300), 18'h00001);
        // Drain everything; the upper data bit proves the full bus width.
        rd_ready = 1'b1;
        for (lvl = 0; lvl < acc; lvl++) begin
            t = 0;
            do begin
                @(negedge clk_sys);
                t++;
            end while (rd_valid !== 1'b1 && t < 40);
            if (rd_valid !== 1'b1) begin
                err_count++;
                report_and_stop();
            end
            check(rd_data, {2'b10, lvl[15:0]});
        end
        @(negedge clk_sys);
        rd_ready = 1'b0;
        idle(8);
        check(flags(), 18'h0001c);
        report_and_stop();
    end
endmodule // testbench
